/* File: verilog/adc_ctrl_pkg.sv */
// Package with register layout, timing constants and states of the converter control.
package adc_ctrl_pkg;

	// ****************************************
	// Control register layout
	// ****************************************
	localparam logic [7:0] CTRL_RESET = 8'h80;
	localparam int HALT_POS = 7;
	localparam int AMP_POS = 6;
	localparam int TRIG_POS = 5;
	localparam int REPEAT_POS = 4;
	localparam int SCAN_POS = 3;
	localparam int RSVD_POS = 2;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 1;
	localparam logic [1:0] SCAN_TWO = 2'h1;
	localparam logic [1:0] SCAN_FOUR = 2'h3;
	localparam logic [1:0] CHAN_ZERO = 2'h0;
	localparam logic [1:0] CHAN_ONE = 2'h1;
	localparam logic [1:0] CHAN_THREE = 2'h3;
	localparam logic [7:0] RESULT_MAX = 8'hFF;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_RATE = 115200;
	localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
	localparam int FRAME_BITS = 10;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ARM = 3'b001,
		ST_START = 3'b010,
		ST_WAIT = 3'b011,
		ST_SEND = 3'b100
	} conv_state_t;

	// A sweep with an even channel code has no defined channel set.
	function automatic logic cfg_valid(input logic [7:0] cfg);
		cfg_valid = !cfg[SCAN_POS] || cfg[SEL_LSB];
	endfunction

	// First channel of a pass: channel zero when sweeping, else the selected one.
	function automatic logic [1:0] first_chan(input logic [7:0] cfg);
		first_chan = cfg[SCAN_POS] ? CHAN_ZERO : cfg[SEL_MSB:SEL_LSB];
	endfunction

	// Last channel of a pass.
	function automatic logic [1:0] last_chan(input logic [7:0] cfg);
		if (!cfg[SCAN_POS]) begin
			last_chan = cfg[SEL_MSB:SEL_LSB];
		end else if (cfg[SEL_MSB:SEL_LSB] == SCAN_FOUR) begin
			last_chan = CHAN_THREE;
		end else begin
			last_chan = CHAN_ONE;
		end
	endfunction

endpackage

/* File: verilog/sample_if.sv */
// Interface carrying one converted sample from the sequencer to the serial sender.
`timescale 1ns/1ps
interface sample_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface

/* File: verilog/sample_tx.sv */
// Serial sender that frames each 8-bit sample with a start and a stop bit.
`timescale 1ns/1ps
module sample_tx #(
	parameter int BIT_CYCLES = adc_ctrl_pkg::BIT_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sample stream
	sample_if.snk link,
	// Serial line
	output logic tx_line
);
	logic [9:0] shift;
	logic [9:0] next_shift;
	logic [3:0] bits_left;
	logic [3:0] next_bits_left;
	logic [15:0] tick;
	logic [15:0] next_tick;
	logic next_tx_line;

	// A sample may load on the last tick of the stop bit, so back-to-back frames leave no
	// idle gap and a steady stream runs at exactly ten bit times per sample.
	assign link.ready = (bits_left == 4'h0) || ((bits_left == 4'h1) && (tick == 16'h0000));

	always_comb begin
		next_shift = shift;
		next_bits_left = bits_left;
		next_tick = tick;
		next_tx_line = tx_line;
		if (link.ready && link.valid) begin
			next_shift = {1'b1, link.data, 1'b0};
			next_bits_left = 4'(adc_ctrl_pkg::FRAME_BITS);
			next_tick = 16'(BIT_CYCLES - 1);
			next_tx_line = 1'b0;
		end else if (bits_left != 4'h0) begin
			if (tick == 16'h0000) begin
				next_shift = {1'b1, shift[9:1]};
				next_bits_left = bits_left - 4'h1;
				next_tick = 16'(BIT_CYCLES - 1);
				next_tx_line = (bits_left == 4'h1) ? 1'b1 : shift[1];
			end else begin
				next_tick = tick - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			shift <= 10'h3FF;
			bits_left <= 4'h0;
			tick <= 16'h0000;
			tx_line <= 1'b1;
		end else begin
			shift <= next_shift;
			bits_left <= next_bits_left;
			tick <= next_tick;
			tx_line <= next_tx_line;
		end
	end

endmodule

/* File: verilog/adc_conversion_control.sv */
// Converter control: control register, trigger, channel sequencing and result hand-off.
//
// Contract
// - Reset leaves control register at 128.
// - Runs alongside other functions, never blocking.
// - Write with halt clear starts conversions.
// - Continuous rate is baud rate over ten.
// - Setting halt stops all conversions at once.
// - Write with halt set only stores.
// - One-shot completion sets halt bit again.
// - Bit 6 routes input through amplifier.
// - Bit 6 selects amplifier output without amplifier.
// - Hardware trigger waits for falling trigger edge.
// - Software trigger starts once halt clears.
// - Continuous single channel converts repeatedly.
// - Continuous sweep cycles the active channels.
// - Clearing repeat bit while running stops.
// - Channel code selects input zero to three.
// - Sweep codes: 01 two, 11 four.
// - Result is 8 bits, clamped, sent serially.
`timescale 1ns/1ps
module adc_conversion_control #(
	parameter int RAW_W = 9,
	parameter int BIT_CYCLES = adc_ctrl_pkg::BIT_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register access from the command parser
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	output logic [7:0] reg_rd_data,
	// Trigger pin
	input wire logic hw_trigger_pin,
	// Analog front end
	output logic [1:0] input_select_field,
	output logic amp_route,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [RAW_W-1:0] conv_raw,
	// Results and status
	output logic [7:0] last_result,
	output logic busy,
	output logic tx_line
);

	// ****************************************
	// State
	// ****************************************
	adc_ctrl_pkg::conv_state_t state;
	adc_ctrl_pkg::conv_state_t next_state;
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [1:0] chan;
	logic [1:0] next_chan;
	logic [7:0] next_result;
	logic next_conv_start;
	logic trig_prev;
	logic trig_fall;
	logic at_last;
	sample_if link ();

	assign reg_rd_data = ctrl;
	assign input_select_field = chan;
	// The front end uses the amplifier path, or the amplifier output pin as a fifth input.
	assign amp_route = ctrl[adc_ctrl_pkg::AMP_POS];
	assign busy = (state != adc_ctrl_pkg::ST_IDLE);
	assign trig_fall = trig_prev && !hw_trigger_pin;
	assign at_last = (chan == adc_ctrl_pkg::last_chan(ctrl));
	assign link.data = last_result;
	assign link.valid = (state == adc_ctrl_pkg::ST_SEND);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		next_state = state;
		next_ctrl = ctrl;
		next_chan = chan;
		next_result = last_result;
		next_conv_start = 1'b0;
		if (reg_wr_en) begin
			next_ctrl = reg_wr_data;
			if (reg_wr_data[adc_ctrl_pkg::HALT_POS]) begin
				next_state = adc_ctrl_pkg::ST_IDLE;
			end else if (busy && ctrl[adc_ctrl_pkg::REPEAT_POS]
					&& !reg_wr_data[adc_ctrl_pkg::REPEAT_POS]) begin
				next_ctrl[adc_ctrl_pkg::HALT_POS] = 1'b1;
				next_state = adc_ctrl_pkg::ST_IDLE;
			end else if (!adc_ctrl_pkg::cfg_valid(reg_wr_data)) begin
				next_state = adc_ctrl_pkg::ST_IDLE;
			end else begin
				next_chan = adc_ctrl_pkg::first_chan(reg_wr_data);
				if (reg_wr_data[adc_ctrl_pkg::TRIG_POS]) begin
					next_state = adc_ctrl_pkg::ST_ARM;
				end else begin
					next_state = adc_ctrl_pkg::ST_START;
				end
			end
		end else begin
			case (state)
				adc_ctrl_pkg::ST_IDLE: begin
					next_state = adc_ctrl_pkg::ST_IDLE;
				end
				adc_ctrl_pkg::ST_ARM: begin
					if (trig_fall) begin
						next_state = adc_ctrl_pkg::ST_START;
					end
				end
				adc_ctrl_pkg::ST_START: begin
					next_conv_start = 1'b1;
					next_state = adc_ctrl_pkg::ST_WAIT;
				end
				adc_ctrl_pkg::ST_WAIT: begin
					if (conv_done) begin
						if (conv_raw > RAW_W'(adc_ctrl_pkg::RESULT_MAX)) begin
							next_result = adc_ctrl_pkg::RESULT_MAX;
						end else begin
							next_result = conv_raw[7:0];
						end
						if (!ctrl[adc_ctrl_pkg::REPEAT_POS] && at_last) begin
							next_ctrl[adc_ctrl_pkg::HALT_POS] = 1'b1;
						end
						next_state = adc_ctrl_pkg::ST_SEND;
					end
				end
				adc_ctrl_pkg::ST_SEND: begin
					// The next conversion starts only when the sender frees up, which
					// paces continuous sampling at one sample per ten bit times.
					if (link.ready) begin
						if (ctrl[adc_ctrl_pkg::HALT_POS]) begin
							next_state = adc_ctrl_pkg::ST_IDLE;
						end else begin
							if (at_last) begin
								next_chan = adc_ctrl_pkg::first_chan(ctrl);
							end else begin
								next_chan = chan + 2'h1;
							end
							next_state = adc_ctrl_pkg::ST_START;
						end
					end
				end
				default: begin
					next_state = adc_ctrl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= adc_ctrl_pkg::ST_IDLE;
			ctrl <= adc_ctrl_pkg::CTRL_RESET;
			chan <= adc_ctrl_pkg::CHAN_ZERO;
			last_result <= 8'h00;
			conv_start <= 1'b0;
			trig_prev <= 1'b1;
		end else begin
			state <= next_state;
			ctrl <= next_ctrl;
			chan <= next_chan;
			last_result <= next_result;
			conv_start <= next_conv_start;
			trig_prev <= hw_trigger_pin;
		end
	end

	// ****************************************
	// Serial output
	// ****************************************
	// The sender is private to this block, so other functions never wait on it.
	sample_tx #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_tx (
		.clk(clk),
		.rst(rst),
		.link(link.snk),
		.tx_line(tx_line)
	);

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_launch;
		(state == adc_ctrl_pkg::ST_START) ##1 conv_start;
	endsequence

	sequence s_sw_write;
		reg_wr_en && !reg_wr_data[adc_ctrl_pkg::HALT_POS]
			&& !reg_wr_data[adc_ctrl_pkg::TRIG_POS] && adc_ctrl_pkg::cfg_valid(reg_wr_data)
			&& !(busy && ctrl[adc_ctrl_pkg::REPEAT_POS]
			&& !reg_wr_data[adc_ctrl_pkg::REPEAT_POS]);
	endsequence

	property p_reset_value;
		@(posedge clk) rst |=> (reg_rd_data == adc_ctrl_pkg::CTRL_RESET);
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("bad control reset value");

	property p_halt_stop;
		@(posedge clk) disable iff (rst)
		reg_wr_en && reg_wr_data[adc_ctrl_pkg::HALT_POS] |=> !busy ##1 !conv_start;
	endproperty
	a_halt_stop: assert property (p_halt_stop) else $error("halt did not stop");

	property p_idle_quiet;
		@(posedge clk) disable iff (rst)
		(state == adc_ctrl_pkg::ST_IDLE) && !reg_wr_en |=> !conv_start && !busy;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("start while halted");

	property p_sw_start;
		@(posedge clk) disable iff (rst)
		s_sw_write |=> ((state == adc_ctrl_pkg::ST_START) && reg_wr_en) or s_launch;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("software start missing");

	property p_hw_wait;
		@(posedge clk) disable iff (rst)
		(state == adc_ctrl_pkg::ST_ARM) && !trig_fall && !reg_wr_en
			|=> (state == adc_ctrl_pkg::ST_ARM) && !conv_start;
	endproperty
	a_hw_wait: assert property (p_hw_wait) else $error("started without trigger edge");

	property p_oneshot_halt;
		@(posedge clk) disable iff (rst)
		(state == adc_ctrl_pkg::ST_WAIT) && conv_done && !reg_wr_en
			&& !ctrl[adc_ctrl_pkg::REPEAT_POS] && at_last |=> reg_rd_data[adc_ctrl_pkg::HALT_POS];
	endproperty
	a_oneshot_halt: assert property (p_oneshot_halt) else $error("one-shot left halt clear");

	property p_repeat_stop;
		@(posedge clk) disable iff (rst)
		reg_wr_en && busy && ctrl[adc_ctrl_pkg::REPEAT_POS]
			&& !reg_wr_data[adc_ctrl_pkg::REPEAT_POS]
			|=> !busy && reg_rd_data[adc_ctrl_pkg::HALT_POS];
	endproperty
	a_repeat_stop: assert property (p_repeat_stop) else $error("repeat clear did not stop");

	property p_bad_sweep;
		@(posedge clk) disable iff (rst)
		reg_wr_en && !reg_wr_data[adc_ctrl_pkg::HALT_POS] && !adc_ctrl_pkg::cfg_valid(reg_wr_data)
			|=> !busy && !reg_rd_data[adc_ctrl_pkg::HALT_POS];
	endproperty
	a_bad_sweep: assert property (p_bad_sweep) else $error("undefined sweep converted");

	property p_clamp;
		@(posedge clk) disable iff (rst)
		(state == adc_ctrl_pkg::ST_WAIT) && conv_done && !reg_wr_en
			&& (conv_raw > RAW_W'(adc_ctrl_pkg::RESULT_MAX)) |=> (last_result == 8'hFF);
	endproperty
	a_clamp: assert property (p_clamp) else $error("result not clamped");

	property p_single_chan;
		@(posedge clk) disable iff (rst)
		s_sw_write and !reg_wr_data[adc_ctrl_pkg::SCAN_POS]
			|=> (input_select_field == $past(reg_wr_data[1:0]));
	endproperty
	a_single_chan: assert property (p_single_chan) else $error("wrong channel");

	property p_sweep_wrap;
		@(posedge clk) disable iff (rst)
		(state == adc_ctrl_pkg::ST_SEND) && link.ready && !reg_wr_en
			&& !ctrl[adc_ctrl_pkg::HALT_POS] && ctrl[adc_ctrl_pkg::SCAN_POS] && at_last
			|=> (input_select_field == 2'h0);
	endproperty
	a_sweep_wrap: assert property (p_sweep_wrap) else $error("sweep did not wrap");

	sequence s_handoff;
		(state == adc_ctrl_pkg::ST_SEND) && link.ready && !reg_wr_en
			&& !ctrl[adc_ctrl_pkg::HALT_POS];
	endsequence

	property p_rate;
		@(posedge clk) disable iff (rst)
		s_handoff ##1 !reg_wr_en |-> s_launch;
	endproperty
	a_rate: assert property (p_rate) else $error("next sample not launched at once");

	property p_repeat_single;
		@(posedge clk) disable iff (rst)
		s_handoff and !ctrl[adc_ctrl_pkg::SCAN_POS]
			|=> (input_select_field == $past(ctrl[1:0]));
	endproperty
	a_repeat_single: assert property (p_repeat_single) else $error("repeat changed channel");

	property p_sweep_step;
		@(posedge clk) disable iff (rst)
		s_handoff and (ctrl[adc_ctrl_pkg::SCAN_POS] && !at_last)
			|=> (input_select_field == $past(chan) + 2'h1);
	endproperty
	a_sweep_step: assert property (p_sweep_step) else $error("sweep skipped a channel");

	property p_hw_fire;
		@(posedge clk) disable iff (rst)
		(state == adc_ctrl_pkg::ST_ARM) && trig_fall && !reg_wr_en
			|=> (state == adc_ctrl_pkg::ST_START);
	endproperty
	a_hw_fire: assert property (p_hw_fire) else $error("trigger edge ignored");

	property p_frame_start;
		@(posedge clk) disable iff (rst)
		link.valid && link.ready |=> !tx_line;
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("no start bit after hand-off");

	property p_one_pulse;
		@(posedge clk) disable iff (rst)
		conv_start |=> !conv_start;
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("start pulse too long");

endmodule

/* File: verification/front_end_model.sv */
// Behavioural model of the analog front end that answers conversion requests.
`timescale 1ns/1ps
module front_end_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Conversion request
	input wire logic conv_start,
	input wire logic [1:0] input_select_field,
	input wire logic amp_route,
	input wire logic slow,
	// Conversion answer
	output logic conv_done,
	output logic [8:0] conv_raw
);
	int cnt;
	logic [8:0] val;

	// The raw bus shows the inverse of its last value outside the done cycle, so a stale
	// value can never be taken for a fresh one. The amplifier path is modelled as overrange.
	always @(posedge clk) begin
		if (rst) begin
			cnt <= 0;
			val <= 9'h000;
			conv_done <= 1'b0;
			conv_raw <= 9'h000;
		end else begin
			if (conv_start === 1'b1) begin
				cnt <= slow ? 30 : 3;
				val <= amp_route ? 9'h1A5 : {1'b0, input_select_field, 6'h15};
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
			end
			conv_done <= (cnt == 1);
			conv_raw <= (cnt == 1) ? val : ~conv_raw;
		end
	end
endmodule

/* File: verification/adc_conversion_control_bench.sv */
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin err_total++; \
	$display("CHECK FAILED at %0t: %s", $time, m); end end
module adc_conversion_control_bench;
	localparam int BC = 4;
	logic clk, rst, reg_wr_en, hw_trigger_pin, conv_start, conv_done, amp_route;
	logic busy, tx_line, slow;
	logic [7:0] reg_wr_data, reg_rd_data, last_result;
	logic [1:0] input_select_field;
	logic [8:0] conv_raw;
	int err_total, n_tests, n_start, i, k;
	time t_start, t1;
	logic [7:0] undef_codes [2] = '{8'h08, 8'h0A};

	adc_conversion_control #(.RAW_W(9), .BIT_CYCLES(BC)) uut (.clk(clk), .rst(rst),
		.reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
		.hw_trigger_pin(hw_trigger_pin), .input_select_field(input_select_field),
		.amp_route(amp_route), .conv_start(conv_start), .conv_done(conv_done),
		.conv_raw(conv_raw), .last_result(last_result), .busy(busy), .tx_line(tx_line));

	front_end_model fe (.clk(clk), .rst(rst), .conv_start(conv_start),
		.input_select_field(input_select_field), .amp_route(amp_route), .slow(slow),
		.conv_done(conv_done), .conv_raw(conv_raw));

	// ****************************************
	// Clock, monitors and tasks
	// ****************************************
	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (conv_start === 1'b1) begin
			n_start++;
		end
	end

	task results;
		if (err_total == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Reserved bit 2 is always written as zero by every caller.
	task wr(input logic [7:0] d);
		@(negedge clk);
		reg_wr_en = 1'b1;
		reg_wr_data = d & 8'hFB;
		@(negedge clk);
		reg_wr_en = 1'b0;
	endtask

	// Receives one serial frame, sampling each bit in its middle.
	task rx(input logic [7:0] e);
		logic [7:0] d;
		int n;
		n = 0;
		while (tx_line !== 1'b0 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		`CHK(n < 3000, 1'b1, "no start bit on the serial line")
		t_start = $time;
		repeat (BC / 2) @(negedge clk);
		for (int j = 0; j < 8; j++) begin
			repeat (BC) @(negedge clk);
			d[j] = tx_line;
		end
		repeat (BC) @(negedge clk);
		`CHK({d, tx_line}, {e, 1'b1}, "serial sample byte or stop bit")
	endtask

	task idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		reg_wr_en = 1'b0;
		reg_wr_data = 8'h00;
		hw_trigger_pin = 1'b1;
		slow = 1'b1;
		err_total = 0;
		n_tests = 0;
		n_start = 0;
		idle(16);
		rst = 1'b0;
		`CHK({reg_rd_data, busy, tx_line}, 10'h201, "reset state")
		wr(8'h93);
		idle(40);
		`CHK(reg_rd_data, 8'h93, "configuration not stored")
		`CHK(n_start, 0, "conversion while halted")
		for (i = 0; i < 4; i++) begin
			wr(i[7:0]);
			`CHK({busy, input_select_field}, {1'b1, i[1:0]}, "no start or wrong input")
			rx({i[1:0], 6'h15});
			`CHK(reg_rd_data, 8'h80 | i[7:0], "halt not set after one-shot")
			`CHK(last_result, {i[1:0], 6'h15}, "last result")
		end
		`CHK(n_start, 4, "one-shot conversion count")
		slow = 1'b0;
		wr(8'h42);
		`CHK(amp_route, 1'b1, "amplifier path not selected")
		rx(8'hFF);
		wr(8'h21);
		idle(20);
		`CHK(n_start, 5, "start without trigger edge")
		hw_trigger_pin = 1'b0;
		rx({2'h1, 6'h15});
		hw_trigger_pin = 1'b1;
		wr(8'h12);
		rx({2'h2, 6'h15});
		t1 = t_start;
		rx({2'h2, 6'h15});
		`CHK(t_start - t1, 64'h190, "continuous sample period")
		rx({2'h2, 6'h15});
		wr(8'h02);
		idle(60);
		k = n_start;
		idle(100);
		`CHK(n_start, k, "conversions after repeat bit cleared")
		`CHK(reg_rd_data, 8'h82, "halt not forced on stop")
		wr(8'h1B);
		for (i = 0; i < 6; i++) begin
			rx({i[1:0], 6'h15});
		end
		wr(8'h9B);
		k = n_start;
		idle(100);
		`CHK({n_start == k, busy}, 2'h2, "conversions after halt")
		wr(8'h09);
		rx({2'h0, 6'h15});
		rx({2'h1, 6'h15});
		idle(50);
		`CHK(reg_rd_data, 8'h89, "halt not set after one-shot sweep")
		foreach (undef_codes[u]) begin
			k = n_start;
			wr(undef_codes[u]);
			idle(50);
			`CHK(n_start, k, "conversion with undefined sweep code")
			`CHK(reg_rd_data, undef_codes[u], "undefined sweep code changed halt")
		end
		results;
	end

	// The sequence takes some 1350 cycles; this bound leaves ample margin.
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		results;
	end
endmodule
